// file: verilog/aux_pin_defs.vh
// Register indices, field positions, reset values and timing for the auxiliary pin block
`ifndef AUX_PIN_DEFS_VH
`define AUX_PIN_DEFS_VH

// ==========================================================================
// Register indices (byte address is four times the index)
// ==========================================================================
`define PIN_CONFIG_INDEX 8'h16
`define PIN_LEVEL_INDEX 8'h17

// ==========================================================================
// Field positions
// ==========================================================================
`define TWO_WIRE_SELECT_BIT 15
`define DIGITAL_SELECT_LSB 8
`define DIRECTION_LSB 0
`define DRIVE_LEVEL_LSB 8
`define INPUT_LEVEL_LSB 0

// ==========================================================================
// Reset values and writable bits
// ==========================================================================
`define PIN_CONFIG_RESET 16'h3F00
`define PIN_LEVEL_RESET 16'h0000
`define PIN_CONFIG_WRITE_MASK 16'hBF3F
`define PIN_LEVEL_WRITE_MASK 16'h3F00

// ==========================================================================
// Timing
// ==========================================================================
`define SYNC_STAGES 3
`define APB_WAIT_STATES 1

`endif

// file: verilog/pin_input_sync.v
// Three-stage pin synchroniser whose output changes once stages two and three agree
`timescale 1ns/1ps

module pin_input_sync #(
  parameter WIDTH = 6
) (
  input wire pclk,
  input wire presetn,
  input wire [WIDTH-1:0] pin_async,
  output reg [WIDTH-1:0] pin_level
);

  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;
  reg [WIDTH-1:0] stage3;
  integer i;

  // ========================================================================
  // Stage one is read by stage two only, never by the agreement check
  // ========================================================================
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stage1 <= {WIDTH{1'b0}};
      stage2 <= {WIDTH{1'b0}};
      stage3 <= {WIDTH{1'b0}};
      pin_level <= {WIDTH{1'b0}};
    end
    else
    begin
      stage1 <= pin_async;
      stage2 <= stage1;
      stage3 <= stage2;
      for (i = 0; i < WIDTH; i = i + 1)
      begin
        if (stage2[i] == stage3[i])
        begin
          pin_level[i] <= stage3[i];
        end
      end
    end
  end

endmodule // pin_input_sync

// file: verilog/aux_pin_level_control.v
// Auxiliary pin drive levels, configuration and input readback behind an APB slave
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
`include "aux_pin_defs.vh"

module aux_pin_level_control #(
  parameter ADDR_WIDTH = 12,
  parameter PIN_COUNT = 6
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_WIDTH-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire address_parity_done,
  input wire [PIN_COUNT-1:0] pin_in,
  input wire twc_sda_drive_low,
  input wire twc_scl_drive_low,
  output reg [PIN_COUNT-1:0] pin_out,
  output reg [PIN_COUNT-1:0] pin_oe,
  output reg twc_sda_level,
  output reg twc_scl_level
);

  // ========================================================================
  // Address decode
  // ========================================================================
  function hit;
    input [ADDR_WIDTH-1:0] addr;
    input [7:0] index;
    begin
      hit = (addr == {{(ADDR_WIDTH-10){1'b0}}, index, 2'b00});
    end
  endfunction

  // Merge a write into a 16-bit register honouring byte strobes and writable bits
  function [15:0] merge;
    input [15:0] old_value;
    input [15:0] new_value;
    input [1:0] strobe;
    input [15:0] write_mask;
    reg [15:0] lane_mask;
    begin
      lane_mask = {{8{strobe[1]}}, {8{strobe[0]}}} & write_mask;
      merge = (old_value & ~lane_mask) | (new_value & lane_mask);
    end
  endfunction

  // ========================================================================
  // State
  // ========================================================================
  reg [15:0] pin_config;
  reg [15:0] pin_level_control;
  reg [PIN_COUNT-1:0] input_snapshot;
  reg [15:0] next_pin_config;
  reg [15:0] next_pin_level_control;
  reg [PIN_COUNT-1:0] next_input_snapshot;
  reg [31:0] next_prdata;
  reg next_pready;
  reg next_pslverr;
  reg [PIN_COUNT-1:0] next_pin_out;
  reg [PIN_COUNT-1:0] next_pin_oe;

  wire [PIN_COUNT-1:0] pin_sync;
  wire [PIN_COUNT-1:0] digital_pin_select;
  wire [PIN_COUNT-1:0] pin_direction;
  wire [PIN_COUNT-1:0] pin_drive_level;
  wire two_wire_controller_select;
  wire [PIN_COUNT-1:0] two_wire_pins;
  wire [PIN_COUNT-1:0] pin_input_level;
  wire setup_phase;
  wire access_done;
  wire config_hit;
  wire level_hit;

  assign digital_pin_select = pin_config[`DIGITAL_SELECT_LSB +: PIN_COUNT];
  assign pin_direction = pin_config[`DIRECTION_LSB +: PIN_COUNT];
  assign two_wire_controller_select = pin_config[`TWO_WIRE_SELECT_BIT];
  assign pin_drive_level = pin_level_control[`DRIVE_LEVEL_LSB +: PIN_COUNT];
  // Pins 0 and 1 belong to the two-wire controller while that mode is on
  assign two_wire_pins = {{(PIN_COUNT-2){1'b0}}, {2{two_wire_controller_select}}};

  // Analog pins and the two-wire pins read zero whatever the pin does
  assign pin_input_level = pin_sync & digital_pin_select & ~two_wire_pins;

  assign setup_phase = psel && !penable;
  assign access_done = psel && penable && pready;
  assign config_hit = hit(paddr, `PIN_CONFIG_INDEX);
  assign level_hit = hit(paddr, `PIN_LEVEL_INDEX);

  // ========================================================================
  // Pin input synchroniser
  // ========================================================================
  pin_input_sync #(
    .WIDTH(PIN_COUNT)
  ) u_pin_input_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_async(pin_in),
    .pin_level(pin_sync)
  );

  // ========================================================================
  // Input level capture
  // ========================================================================
  // The link decoder strobes at the end of the address parity bit; an APB
  // read of the level register captures at its setup phase, the equivalent
  // point where the address is known. Data stays frozen for the whole read.
  always @*
  begin
    next_input_snapshot = input_snapshot;
    if (address_parity_done || (setup_phase && !pwrite && level_hit))
    begin
      next_input_snapshot = pin_input_level;
    end
  end

  // ========================================================================
  // Register writes
  // ========================================================================
  always @*
  begin
    next_pin_config = pin_config;
    next_pin_level_control = pin_level_control;
    if (access_done && pwrite)
    begin
      if (config_hit)
      begin
        next_pin_config = merge(pin_config, pwdata[15:0], pstrb[1:0],
                                `PIN_CONFIG_WRITE_MASK);
      end
      if (level_hit)
      begin
        // Input level bits are read only, so only bits 13:8 are writable
        next_pin_level_control = merge(pin_level_control, pwdata[15:0], pstrb[1:0],
                                       `PIN_LEVEL_WRITE_MASK);
      end
    end
  end

  // ========================================================================
  // APB answer: one wait state, read data and error registered
  // ========================================================================
  always @*
  begin
    next_pready = 1'b0;
    next_prdata = prdata;
    next_pslverr = 1'b0;
    if (psel && penable && !pready)
    begin
      next_pready = 1'b1;
      next_pslverr = !(config_hit || level_hit);
      next_prdata = 32'h00000000;
      if (!pwrite && config_hit)
      begin
        next_prdata = {16'h0000, pin_config};
      end
      if (!pwrite && level_hit)
      begin
        // Stored drive bits read back even when two-wire mode ignores them
        next_prdata = {16'h0000, pin_level_control};
        next_prdata[`INPUT_LEVEL_LSB +: PIN_COUNT] = input_snapshot;
      end
    end
  end

  // ========================================================================
  // Pin drive
  // ========================================================================
  always @*
  begin
    next_pin_oe = digital_pin_select & pin_direction & ~two_wire_pins;
    next_pin_out = pin_drive_level & next_pin_oe;
    if (two_wire_controller_select)
    begin
      // Open drain: drive low only, release for high
      next_pin_oe[0] = twc_sda_drive_low;
      next_pin_oe[1] = twc_scl_drive_low;
      next_pin_out[0] = 1'b0;
      next_pin_out[1] = 1'b0;
    end
  end

  // ========================================================================
  // Register file
  // ========================================================================
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_config <= `PIN_CONFIG_RESET;
      pin_level_control <= `PIN_LEVEL_RESET;
    end
    else
    begin
      pin_config <= next_pin_config;
      pin_level_control <= next_pin_level_control;
    end
  end

  // ========================================================================
  // Input snapshot
  // ========================================================================
  // Cleared by reset; a read still returns the synchroniser output captured at its
  // setup phase, which reset also clears to zeros until stages two and three agree
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      input_snapshot <= {PIN_COUNT{1'b0}};
    end
    else
    begin
      input_snapshot <= next_input_snapshot;
    end
  end

  // ========================================================================
  // APB answer flip-flops
  // ========================================================================
  // Ready is registered so the answer never depends combinationally on
  // paddr; the price is one fixed wait state on every transfer
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ========================================================================
  // Pin drive flip-flops
  // ========================================================================
  // Enable and level change on the same edge, so a pin never drives
  // a stale level for one cycle while it turns round
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_out <= {PIN_COUNT{1'b0}};
      pin_oe <= {PIN_COUNT{1'b0}};
    end
    else
    begin
      pin_out <= next_pin_out;
      pin_oe <= next_pin_oe;
    end
  end

  // ========================================================================
  // Two-wire line levels
  // ========================================================================
  // Zero when the mode is off; taken from the agreed synchroniser output
  // so that a short glitch on a line is not seen as a clock or data edge
  // by the two-wire controller
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      twc_sda_level <= 1'b0;
      twc_scl_level <= 1'b0;
    end
    else
    begin
      twc_sda_level <= pin_sync[0] & two_wire_controller_select;
      twc_scl_level <= pin_sync[1] & two_wire_controller_select;
    end
  end

endmodule // aux_pin_level_control

// file: test/aux_pin_level_control_props.sv
// Port-level checker for the auxiliary pin block
`timescale 1ns/1ps
module aux_pin_props (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire twc_sda_drive_low,
  input wire twc_scl_drive_low,
  input wire [5:0] pin_out,
  input wire [5:0] pin_oe
);
  localparam [11:0] CFG = 12'h058;
  localparam [11:0] LVL = 12'h05C;
  // ========================================
  // Shadow of the fields, taken from writes
  reg tw;
  reg [5:0] dsel, dir, drv;
  wire wr_ok = pready && pwrite && !pslverr;
  wire rd_lvl = pready && !pwrite && paddr == LVL;
  wire [5:0] exp_oe = tw ? {dsel[5:2] & dir[5:2], twc_scl_drive_low, twc_sda_drive_low} :
    dsel & dir;
  wire [5:0] exp_out = tw ? {drv[5:2], 2'h0} : drv;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tw <= 1'h0;
      dsel <= 6'h3F;
      dir <= 6'h00;
      drv <= 6'h00;
    end
    else if (wr_ok && paddr == CFG)
    begin
      if (pstrb[1]) tw <= pwdata[15];
      if (pstrb[1]) dsel <= pwdata[13:8];
      if (pstrb[0]) dir <= pwdata[5:0];
    end
    else if (wr_ok && paddr == LVL && pstrb[1])
      drv <= pwdata[13:8];
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  chk_answer_delay: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("late answer");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held");
  chk_unmapped_error: assert property (pready |-> pslverr == (paddr != CFG && paddr != LVL))
    else $error("bad error flag");
  chk_level_readback: assert property (rd_lvl |-> prdata[31:6] == {18'h0, drv, 2'h0})
    else $error("bad drive readback");
  chk_input_masked: assert property (rd_lvl |-> !(prdata[5:0] & ~dsel) && !(tw && prdata[1:0]))
    else $error("bad input bits");
  chk_config_readback: assert property (pready && !pwrite && paddr == CFG |->
    prdata == {16'h0, tw, 1'h0, dsel, 2'h0, dir})
    else $error("bad config readback");
  chk_pin_enable: assert property (pin_oe == $past(exp_oe))
    else $error("bad output enable");
  chk_pin_drive: assert property ((pin_out & pin_oe) == ($past(exp_out) & pin_oe))
    else $error("bad pin level");
  cover property (pready && pslverr);
  cover property (rd_lvl && tw);
  cover property (tw && pin_oe[0]);
endmodule // aux_pin_props
bind aux_pin_level_control aux_pin_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .twc_sda_drive_low(twc_sda_drive_low),
  .twc_scl_drive_low(twc_scl_drive_low), .pin_out(pin_out), .pin_oe(pin_oe));

// file: test/aux_pin_level_control_bench.sv
// Register-level bench for the auxiliary pin block
`timescale 1ns/1ps
module aux_pin_level_control_bench;
  localparam logic [11:0] CFG = 12'h058;
  localparam logic [11:0] LVL = 12'h05C;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic sda_low = 1'h0, scl_low = 1'h0, pready, pslverr, err, sda_lvl, scl_lvl;
  logic parity_done = 1'h0;
  logic [3:0] strb = 4'hF;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic [5:0] pin_in = 6'h2A, pin_out, pin_oe;
  int error_cnt = 0, checked = 0, cycles = 0;
  always #10 pclk = ~pclk;
  aux_pin_level_control dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(strb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .address_parity_done(parity_done), .pin_in(pin_in),
    .twc_sda_drive_low(sda_low), .twc_scl_drive_low(scl_low), .pin_out(pin_out),
    .pin_oe(pin_oe), .twc_sda_level(sda_lvl), .twc_scl_level(scl_lvl));
  task report_and_stop;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [32:0] got, input logic [32:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // APB transfer; the wait on pready is bounded only by the cycle ceiling
  task acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task rd(input logic [11:0] a, input logic [32:0] exp);
    acc(1'h0, a, 32'h0);
    chk({err, rdata}, exp);
  endtask
  // Pins follow a register change one edge later
  task pins(input logic [7:0] e_oe, input logic [5:0] e_out);
    repeat (2) @(posedge pclk);
    chk({25'h0, scl_lvl, sda_lvl, pin_oe}, {25'h0, e_oe});
    chk({27'h0, pin_out & pin_oe}, {27'h0, e_out});
  endtask
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      error_cnt++;
      report_and_stop;
    end
  end
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    repeat (6) @(posedge pclk);
    rd(CFG, 33'h0_0000_3F00);
    rd(LVL, 33'h0_0000_002A);
    pins(8'h00, 6'h00);
    acc(1'h1, 12'hFF0, 32'hFFFF_FFFF);
    rd(12'hFF0, 33'h1_0000_0000);
    acc(1'h1, LVL, 32'hFFFF_FFFF);
    rd(LVL, 33'h0_0000_3F2A);
    pins(8'h00, 6'h00);
    $display("test access done");
    acc(1'h1, CFG, 32'h0000_3F3F);
    pins(8'h3F, 6'h3F);
    acc(1'h1, LVL, 32'h0000_1500);
    pins(8'h3F, 6'h15);
    acc(1'h1, CFG, 32'h0000_0F3F);
    pins(8'h0F, 6'h05);
    rd(LVL, 33'h0_0000_150A);
    pin_in <= 6'h15;
    repeat (5) @(posedge pclk);
    parity_done <= 1'h1;
    @(posedge pclk);
    parity_done <= 1'h0;
    rd(LVL, 33'h0_0000_1505);
    $display("test drive done");
    acc(1'h1, CFG, 32'h0000_BF3F);
    sda_low <= 1'h1;
    pins(8'h7D, 6'h14);
    rd(LVL, 33'h0_0000_1514);
    rd(CFG, 33'h0_0000_BF3F);
    sda_low <= 1'h0;
    scl_low <= 1'h1;
    pins(8'h7E, 6'h14);
    acc(1'h1, CFG, 32'h0000_3F3F);
    pins(8'h3F, 6'h15);
    $display("test two-wire done");
    strb <= 4'h1;
    acc(1'h1, LVL, 32'h0000_0000);
    rd(LVL, 33'h0_0000_1515);
    strb <= 4'h2;
    acc(1'h1, LVL, 32'h0000_2AFF);
    pins(8'h3F, 6'h2A);
    strb <= 4'hF;
    $display("test strobe done");
    report_and_stop;
  end
endmodule // aux_pin_level_control_bench
